// *** dv/sbwc_host.sv ***
// Host adapter model: AXI4-Lite master that reaches the task-file registers.
// Assumes one block answering every request; the bench watchdog cuts any hang short.
`timescale 1ns/1ps
`default_nettype none
module sbwc_host
    import sbwc_pkg::*;
(
    input wire logic sys_clk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end

    // Released payload is inverted so a slave sampling late never sees the old value
    task automatic wr(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
        logic aw_open;
        logic w_open;
        @(posedge sys_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {addr, data, 4'hf};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        aw_open = 1'b1;
        w_open = 1'b1;
        do begin
            @(posedge sys_clk);
            if (aw_open && s_axi_awready) begin
                aw_open = 1'b0;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~addr;
            end
            if (w_open && s_axi_wready) begin
                w_open = 1'b0;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~data;
            end
        end while (aw_open || w_open || s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
        @(posedge sys_clk);
        s_axi_araddr <= addr;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~addr;
            end
        end while (s_axi_rvalid !== 1'b1);
        {data, resp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask

    // A command goes out only once the device reports ready and not busy
    task automatic cmd(input logic [7:0] code);
        logic [31:0] st;
        logic [1:0] resp;
        st = '0;
        while (st[ST_READY] !== 1'b1 || st[ST_BUSY] !== 1'b0) begin
            rd(OFS_STATUS, st, resp);
        end
        wr(OFS_COMMAND, {24'h0, code}, resp);
    endtask
endmodule // sbwc_host
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the standby and buffer-write command block.
// Assumes sbwc_host as sole register master; the standby unit is shortened to 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sbwc_pkg::*;
    localparam int UNIT = 4;
    localparam int LIMIT = 20000;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, standby_mode, device_select_bit;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;

    sbwc_top #(.STBY_UNIT_CYC(UNIT), .WORDS(BUF_WORDS)) dut (.sys_clk, .sys_rst,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .standby_mode,
        .device_select_bit);
    sbwc_host host (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);

    always #20 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR time=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_reg(input logic [7:0] addr, input logic [31:0] exp);
        host.rd(addr, rdat, resp);
        check(rdat, exp);
    endtask
    task automatic check_resp(input logic [1:0] exp);
        check({30'h0, resp}, {30'h0, exp});
    endtask
    task automatic check_pin(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask

    // Streams one sector; optionally probes the data request just before the last word
    task automatic fill(input logic [15:0] key, input logic probe);
        for (int i = 0; i < BUF_WORDS; i++) begin
            if (probe && i == BUF_WORDS - 1) check_reg(OFS_STATUS, 32'h48);
            host.wr(OFS_DATA, {16'h0, 16'(i) ^ key}, resp);
        end
    endtask

    task automatic t_reset();
        check_reg(OFS_STATUS, {24'h0, STATUS_RST});
        check_pin(standby_mode, 1'b0);
        host.wr(OFS_STATUS, 32'hff, resp);
        check_resp(RESP_OKAY);
        check_reg(OFS_STATUS, 32'h40);
        host.rd(8'h24, rdat, resp);
        check_resp(RESP_SLVERR);
        check(rdat, 32'h0);
        host.wr(OFS_DEVHEAD, 32'h10, resp);
        check_pin(device_select_bit, 1'b1);
        $display("test reset_and_select done");
    endtask

    task automatic t_standby();
        host.wr(OFS_SECCNT, 32'h3, resp);
        host.cmd(CMD_STANDBY);
        check_reg(OFS_STATUS, 32'h40);
        check_reg(OFS_ERROR, 32'h0);
        check_pin(standby_mode, 1'b1);
        check_reg(OFS_POWER, 32'h3);
        host.wr(OFS_SECCNT, 32'h0, resp);
        host.cmd(CMD_STANDBY);
        check_reg(OFS_POWER, 32'h1);
        check_pin(device_select_bit, 1'b1);
        $display("test standby done");
    endtask

    task automatic t_buffer();
        host.cmd(CMD_WRITE_BUF);
        repeat (20) @(posedge sys_clk);
        check_pin(standby_mode, 1'b0);
        host.wr(OFS_COMMAND, {24'h0, CMD_STANDBY_NOW}, resp);
        check_reg(OFS_STATUS, 32'h48);
        check_pin(standby_mode, 1'b0);
        fill(16'ha5c3, 1'b1);
        check_reg(OFS_STATUS, 32'h40);
        check_reg(OFS_DATA, 32'ha5c3);
        check_reg(OFS_DATA, 32'ha5c2);
        host.cmd(CMD_STANDBY_NOW);
        check_reg(OFS_STATUS, 32'h40);
        check_pin(standby_mode, 1'b1);
        $display("test buffer_and_immediate done");
    endtask

    task automatic t_timer();
        int n;
        host.wr(OFS_SECCNT, 32'h2, resp);
        host.cmd(CMD_STANDBY);
        host.cmd(CMD_WRITE_BUF);
        repeat (2) @(posedge sys_clk);
        check_pin(standby_mode, 1'b0);
        n = 0;
        while (standby_mode !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
        check({31'h0, n >= 2 * UNIT - 3 && n <= 2 * UNIT + 1}, 32'h1);
        fill(16'h3c00, 1'b0);
        check_reg(OFS_STATUS, 32'h40);
        $display("test standby_timer done");
    endtask

    task automatic t_abort();
        logic [3:0] cfgs [5] = '{4'h4, 4'h4, 4'h7, 4'h1, 4'hd};
        logic [7:0] codes [5] = '{CMD_STANDBY, CMD_STANDBY_NOW, CMD_WRITE_BUF, CMD_WRITE_BUF, 8'h00};
        logic [7:0] stat [5] = '{8'h41, 8'h41, 8'h41, 8'h41, 8'h61};
        for (int i = 0; i < 5; i++) begin
            host.wr(OFS_CONFIG, {28'h0, cfgs[i]}, resp);
            host.cmd(codes[i]);
            check_reg(OFS_STATUS, {24'h0, stat[i]});
            check_reg(OFS_ERROR, 32'h4);
        end
        host.wr(OFS_CONFIG, {28'h0, CONFIG_RST}, resp);
        host.cmd(CMD_STANDBY_NOW);
        check_reg(OFS_STATUS, 32'h40);
        check_pin(device_select_bit, 1'b1);
        host.wr(OFS_DEVHEAD, 32'h0, resp);
        check_pin(device_select_bit, 1'b0);
        $display("test aborts done");
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_standby();
        t_buffer();
        t_timer();
        t_abort();
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire

// *** hw/sbwc_top.sv ***
// Standby, standby-immediate and buffer-write command execution with AXI4-Lite registers.
// Assumes a single 25 MHz clock, synchronous reset, one AXI master.
// Function
// - Abort standby commands without power management.
// - Abort when the requested action cannot complete.
// - Clear busy at every command end.
// - Set device ready at completion.
// - Set device fault on error if faulted.
// - Clear device fault on normal completion.
// - Clear data request at every completion.
// - Error status set when any error bit set.
// - Buffer write normal end clears error status.
// - Device select bit always reports selection.
// - Standby command enters standby mode.
// - Nonzero count enables and loads standby timer.
// - Zero count disables standby timer.
// - Code E0h enters standby at once.
// - Immediate standby has no data phase.
// - Code E8h runs PIO data-out transfer.
// - Packet-set devices refuse buffer write.
// - Power management implies immediate standby supported.
// - Count at issue sets timer period.
// - Buffer write and read share 512 bytes.
`timescale 1ns/1ps
`default_nettype none
module sbwc_top
    import sbwc_pkg::*;
#(
    parameter int STBY_UNIT_CYC = 1000,
    parameter int WORDS = sbwc_pkg::BUF_WORDS
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic standby_mode,
    output logic device_select_bit
);
    import sbwc_pkg::*;

    localparam int PW = $clog2(WORDS);
    localparam logic [PW-1:0] LAST_WORD = PW'(WORDS - 1);

    typedef struct packed {
        sbwc_state_type state;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] error_report;
        logic [7:0] sector_count_param;
        logic [7:0] device_select_head;
        logic [7:0] device_status;
        logic [7:0] feature_param;
        logic [7:0] command_code_reg;
        logic [3:0] config_bits;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic tmr_en;
        logic [31:0] tmr_load;
        logic [31:0] tmr_cnt;
        logic standby;
    } sbwc_regs_type;

    sbwc_regs_type s_r;
    sbwc_regs_type s_nxt;
    logic [15:0] buf_mem [WORDS];
    logic mem_we;
    logic [15:0] rd_word;

    function automatic logic addr_mapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= OFS_POWER);
    endfunction

    // Asynchronous read port; a data port read returns the word at rd_ptr
    assign rd_word = buf_mem[s_r.rd_ptr];

    always_comb begin
        logic wr_go;
        logic rd_go;
        logic abort;
        logic [31:0] rd_val;
        wr_go = 1'b0;
        rd_go = 1'b0;
        abort = 1'b0;
        rd_val = 32'h0000_0000;
        s_nxt = s_r;
        mem_we = 1'b0;

        // Write address and data are accepted independently, in either order
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_have = 1'b1;
            s_nxt.w_data = s_axi_wdata;
            s_nxt.w_strb = s_axi_wstrb;
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
            wr_go = 1'b1;
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = addr_mapped(s_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end

        // Standby timer runs only while active and enabled
        if (s_r.tmr_en && !s_r.standby) begin
            if (s_r.tmr_cnt == 32'h0000_0000) begin
                s_nxt.standby = 1'b1;
            end else begin
                s_nxt.tmr_cnt = s_r.tmr_cnt - 32'h0000_0001;
            end
        end

        // Register writes; byte lane 0 must be enabled
        if (wr_go && s_r.w_strb[0]) begin
            case (s_r.aw_addr)
                OFS_SECCNT: s_nxt.sector_count_param = s_r.w_data[7:0];
                OFS_DEVHEAD: s_nxt.device_select_head = s_r.w_data[7:0];
                OFS_FEATURE: s_nxt.feature_param = s_r.w_data[7:0];
                OFS_CONFIG: s_nxt.config_bits = s_r.w_data[3:0];
                OFS_COMMAND: begin
                    // A command written while busy or transferring is dropped
                    if (s_r.state == SBWC_IDLE && s_r.device_status[ST_READY]) begin
                        s_nxt.command_code_reg = s_r.w_data[7:0];
                        s_nxt.device_status[ST_BUSY] = 1'b1;
                        s_nxt.error_report = 8'h00;
                        s_nxt.state = SBWC_EXEC;
                    end
                end
                OFS_DATA: begin
                    if (s_r.state == SBWC_DATA && s_r.w_strb[1]) begin
                        mem_we = 1'b1;
                        s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
                        // Host data traffic is activity, so the idle timer starts over
                        s_nxt.tmr_cnt = s_r.tmr_load;
                        if (s_r.wr_ptr == LAST_WORD) begin
                            // Normal end of the data-out phase
                            s_nxt.state = SBWC_IDLE;
                            s_nxt.device_status[ST_DREQ] = 1'b0;
                            s_nxt.device_status[ST_FAULT] = 1'b0;
                            s_nxt.device_status[ST_ERR] = 1'b0;
                            s_nxt.device_status[ST_READY] = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        case (s_r.state)
            SBWC_IDLE: begin
            end
            SBWC_EXEC: begin
                case (s_r.command_code_reg)
                    CMD_STANDBY, CMD_STANDBY_NOW: begin
                        // Standby-immediate is mandatory once power management exists
                        abort = !s_r.config_bits[CF_PM] || s_r.config_bits[CF_FAULT];
                    end
                    CMD_WRITE_BUF: begin
                        abort = !s_r.config_bits[CF_WBUF] || s_r.config_bits[CF_PACKET]
                            || s_r.config_bits[CF_FAULT];
                    end
                    // Unknown codes abort rather than leave the host waiting
                    default: abort = 1'b1;
                endcase
                s_nxt.device_status[ST_BUSY] = 1'b0;
                s_nxt.device_status[ST_READY] = 1'b1;
                s_nxt.device_status[ST_DREQ] = 1'b0;
                if (abort) begin
                    s_nxt.error_report[ER_ABORT] = 1'b1;
                    s_nxt.device_status[ST_FAULT] = s_r.config_bits[CF_FAULT];
                    s_nxt.device_status[ST_ERR] = 1'b1;
                    s_nxt.state = SBWC_IDLE;
                end else begin
                    s_nxt.device_status[ST_FAULT] = 1'b0;
                    s_nxt.device_status[ST_ERR] = 1'b0;
                    s_nxt.state = SBWC_IDLE;
                    case (s_r.command_code_reg)
                        CMD_STANDBY: begin
                            s_nxt.standby = 1'b1;
                            s_nxt.tmr_en = (s_r.sector_count_param != 8'h00);
                            s_nxt.tmr_load = 32'(s_r.sector_count_param * STBY_UNIT_CYC);
                            s_nxt.tmr_cnt = 32'(s_r.sector_count_param * STBY_UNIT_CYC);
                        end
                        CMD_STANDBY_NOW: begin
                            s_nxt.standby = 1'b1;
                        end
                        default: begin
                            // Buffer write wakes the device and restarts the idle timer
                            s_nxt.standby = 1'b0;
                            s_nxt.tmr_cnt = s_r.tmr_load;
                            s_nxt.wr_ptr = '0;
                            s_nxt.rd_ptr = '0;
                            s_nxt.device_status[ST_DREQ] = 1'b1;
                            s_nxt.state = SBWC_DATA;
                        end
                    endcase
                end
            end
            SBWC_DATA: begin
            end
            default: s_nxt.state = SBWC_IDLE;
        endcase

        // Reads: one outstanding, answered the cycle after acceptance
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_r.arready) begin
            rd_go = 1'b1;
            case (s_axi_araddr)
                OFS_ERROR: rd_val = {24'h000000, s_r.error_report};
                OFS_SECCNT: rd_val = {24'h000000, s_r.sector_count_param};
                OFS_DEVHEAD: rd_val = {24'h000000, s_r.device_select_head};
                OFS_STATUS: rd_val = {24'h000000, s_r.device_status};
                OFS_DATA: rd_val = {16'h0000, rd_word};
                OFS_CONFIG: rd_val = {28'h0000000, s_r.config_bits};
                OFS_POWER: rd_val = {30'h0, s_r.tmr_en, s_r.standby};
                default: rd_val = 32'h0000_0000;
            endcase
            // Sequential reads of the data port walk the same 512 bytes just written
            if (s_axi_araddr == OFS_DATA) begin
                s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
            end
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_val;
            s_nxt.rresp = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end

        // Readies follow the next state so a taken beat is never taken twice
        s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;
        s_nxt.arready = !s_nxt.rvalid && !rd_go;
    end

    // Reset leaves the device ready, with power management and buffer write on
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.state <= SBWC_IDLE;
            s_r.device_status <= STATUS_RST;
            s_r.config_bits <= CONFIG_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Buffer storage kept outside the state record; it has no reset
    always_ff @(posedge sys_clk) begin
        if (mem_we) begin
            buf_mem[s_r.wr_ptr] <= s_r.w_data[15:0];
        end
    end

    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign standby_mode = s_r.standby;
    assign device_select_bit = s_r.device_select_head[DH_DEVSEL];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    logic exec_r;
    logic [7:0] cmd_r;
    assign exec_r = (s_r.state == SBWC_EXEC);
    assign cmd_r = s_r.command_code_reg;

    // Completion status of every command
    AST_BUSY_ONE_CYCLE: assert property ($rose(s_r.device_status[ST_BUSY]) |=>
        !s_r.device_status[ST_BUSY] && s_r.device_status[ST_READY])
        else $error("busy not cleared one cycle after command start");
    AST_END_NO_DREQ: assert property (exec_r && cmd_r != CMD_WRITE_BUF |=>
        !s_r.device_status[ST_DREQ] && s_r.state == SBWC_IDLE)
        else $error("data request left set after non-data command");
    AST_ABORT_NO_PM: assert property (exec_r && !s_r.config_bits[CF_PM]
        && (cmd_r == CMD_STANDBY || cmd_r == CMD_STANDBY_NOW) |=>
        s_r.error_report[ER_ABORT] && s_r.device_status[ST_ERR] && !s_r.standby == $past(!s_r.standby))
        else $error("standby without power management not aborted");
    AST_ERR_TRACKS: assert property ($fell(s_r.device_status[ST_BUSY]) |->
        s_r.device_status[ST_ERR] == (s_r.error_report != 8'h00))
        else $error("error status disagrees with error register");
    AST_FAULT_ON_ERROR: assert property (exec_r && s_r.config_bits[CF_FAULT] |=>
        s_r.device_status[ST_FAULT] && s_r.error_report[ER_ABORT])
        else $error("device fault not reported on error");
    AST_WBUF_END: assert property ($fell(s_r.device_status[ST_DREQ]) |->
        !s_r.device_status[ST_ERR] && !s_r.device_status[ST_FAULT] && s_r.state == SBWC_IDLE)
        else $error("buffer write end left error or fault set");
    AST_NOW_STANDBY: assert property (exec_r && cmd_r == CMD_STANDBY_NOW
        && s_r.config_bits[CF_PM] && !s_r.config_bits[CF_FAULT] |=> s_r.standby ##0 !s_r.device_status[ST_DREQ])
        else $error("immediate standby did not enter standby");
    AST_TIMER_LOAD: assert property (exec_r && cmd_r == CMD_STANDBY
        && s_r.config_bits[CF_PM] && !s_r.config_bits[CF_FAULT] |=>
        s_r.tmr_en == ($past(s_r.sector_count_param) != 8'h00) && s_r.standby)
        else $error("standby timer enable wrong after standby command");
    AST_PACKET_REFUSE: assert property (exec_r && cmd_r == CMD_WRITE_BUF
        && s_r.config_bits[CF_PACKET] |=> s_r.error_report[ER_ABORT] && s_r.state == SBWC_IDLE)
        else $error("buffer write accepted with packet feature set");
    // A write of the device/head register shows on the pin one edge later
    AST_DEVSEL: assert property (s_r.aw_have && s_r.w_have && !s_r.bvalid && s_r.w_strb[0]
        && s_r.aw_addr == OFS_DEVHEAD |=> device_select_bit == $past(s_r.w_data[DH_DEVSEL]))
        else $error("device select output does not follow the written value");

    // Command sequencing: execution lasts one cycle and a transfer locks out new commands
    AST_EXEC_ONE: assert property (exec_r |=> s_r.state == SBWC_IDLE || s_r.state == SBWC_DATA)
        else $error("command execution lasted more than one cycle");
    AST_DATA_NO_CMD: assert property (s_r.state == SBWC_DATA |=> !exec_r)
        else $error("command accepted during the data-out phase");
    AST_WBUF_START: assert property (exec_r && cmd_r == CMD_WRITE_BUF && s_r.config_bits[CF_WBUF]
        && !s_r.config_bits[CF_PACKET] && !s_r.config_bits[CF_FAULT] |=>
        s_r.device_status[ST_DREQ] && s_r.state == SBWC_DATA && !s_r.standby)
        else $error("buffer write did not open the data-out phase");

    // Timer expiry; an executing command that does not abort owns the standby bit in that cycle
    AST_TIMER_EXPIRE: assert property (s_r.tmr_en && !s_r.standby && !exec_r
        && s_r.tmr_cnt == 32'h0000_0000 |=> s_r.standby)
        else $error("expired standby timer did not enter standby");

    // Bus handshakes: answers hold until taken, one transfer of each kind at a time
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed before it was taken");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed before it was taken");
    AST_ONE_WRITE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel ready while a response is pending");
    AST_ONE_READ: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready while read data is pending");

    // Main scenarios
    COV_STANDBY: cover property (exec_r && cmd_r == CMD_STANDBY ##1 s_r.tmr_en);
    COV_TIMER_EXPIRE: cover property (!s_r.standby && s_r.tmr_en ##1 s_r.standby);
    COV_WBUF_DONE: cover property ($fell(s_r.device_status[ST_DREQ]));
    COV_ABORT: cover property ($rose(s_r.error_report[ER_ABORT]));
    COV_FAULT_ABORT: cover property ($rose(s_r.device_status[ST_FAULT]));
endmodule // sbwc_top
`default_nettype wire

// *** pkg/sbwc_pkg.sv ***
// Constants for the standby and buffer-write command block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned byte addresses.
package sbwc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_ERROR = 8'h00;
    localparam logic [7:0] OFS_SECCNT = 8'h04;
    localparam logic [7:0] OFS_DEVHEAD = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_FEATURE = 8'h10;
    localparam logic [7:0] OFS_COMMAND = 8'h14;
    localparam logic [7:0] OFS_DATA = 8'h18;
    localparam logic [7:0] OFS_CONFIG = 8'h1c;
    localparam logic [7:0] OFS_POWER = 8'h20;
    // Status bit positions
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_FAULT = 5;
    localparam int ST_DREQ = 3;
    localparam int ST_ERR = 0;
    // Error bit and device-select bit
    localparam int ER_ABORT = 2;
    localparam int DH_DEVSEL = 4;
    // Configuration bit positions
    localparam int CF_PM = 0;
    localparam int CF_PACKET = 1;
    localparam int CF_WBUF = 2;
    localparam int CF_FAULT = 3;
    // Command codes
    localparam logic [7:0] CMD_STANDBY = 8'he2;
    localparam logic [7:0] CMD_STANDBY_NOW = 8'he0;
    localparam logic [7:0] CMD_WRITE_BUF = 8'he8;
    // Reset values
    localparam logic [7:0] STATUS_RST = 8'h40;
    localparam logic [3:0] CONFIG_RST = 4'h5;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Buffer size in 16-bit words (512 bytes)
    localparam int BUF_WORDS = 256;

    typedef enum logic [3:0] {
        SBWC_IDLE = 4'b0001,
        SBWC_EXEC = 4'b0010,
        SBWC_DATA = 4'b0100,
        SBWC_SPARE = 4'b1000
    } sbwc_state_type;
endpackage
